/* File: core/csr_top.sv */
// Charge current and charge voltage setpoint registers with fault clears and current clamps.
`timescale 1ns/1ps
`default_nettype none
module csr_top #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value.
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic input_source_good_i,
  input wire logic input_overvoltage_i,
  input wire logic cell_count_battery_presence_i,
  input wire logic [1:0] cell_count_sel_i,
  input wire logic linear_regulation_mode_i,
  input wire logic battery_below_precharge_i,
  input wire logic battery_below_min_system_i,
  output logic charge_enable_o,
  output logic [6:0] charge_current_code_o,
  output logic [11:0] charge_voltage_code_o,
  output logic battery_path_switch_linear_o
);
  logic [6:0] cur_ff;
  logic [11:0] volt_ff;
  logic [1:0] cells_ff;
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  logic [1:0] good_sync_ff;
  logic [1:0] ovp_sync_ff;
  logic [1:0] pres_sync_ff;
  logic [1:0] cell_sync0_ff;
  logic [1:0] cell_sync1_ff;
  logic [1:0] lin_sync_ff;
  logic [1:0] pre_sync_ff;
  logic [1:0] minsys_sync_ff;
  logic good_prev_ff;
  logic pres_prev_ff;
  logic [7:0] ptr_ff;
  logic first_ff;
  logic have_lsb_ff;
  logic [7:0] lsb_hold_ff;
  logic start_evt;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic tx_req;
  logic [7:0] tx_byte;
  logic data_wr;
  logic [15:0] wr_word;
  logic cur_wr;
  logic volt_wr;
  logic [11:0] volt_field;
  logic volt_zero_wr;
  logic fault_clear;
  logic [6:0] nxt_limit;
  logic nxt_linear;

  // Default charge voltage for a cell count code of 0 to 3 meaning one to four cells.
  function automatic logic [11:0] volt_default(input logic [1:0] cells);
    case (cells)
      2'h0: volt_default = csr_pkg::CSR_VOLT_DEF_1S;
      2'h1: volt_default = csr_pkg::CSR_VOLT_DEF_2S;
      2'h2: volt_default = csr_pkg::CSR_VOLT_DEF_3S;
      default: volt_default = csr_pkg::CSR_VOLT_DEF_4S;
    endcase
  endfunction : volt_default

  // Readback byte for a register address; unmapped addresses read zero.
  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [6:0] cur,
                                           input logic [11:0] volt);
    case (addr)
      csr_pkg::CSR_CUR_LSB_ADDR: read_byte = {cur[1:0], 6'h00};
      csr_pkg::CSR_CUR_MSB_ADDR: read_byte = {3'h0, cur[6:2]};
      csr_pkg::CSR_VOLT_LSB_ADDR: read_byte = {volt[4:0], 3'h0};
      csr_pkg::CSR_VOLT_MSB_ADDR: read_byte = {1'b0, volt[11:5]};
      default: read_byte = 8'h00;
    endcase
  endfunction : read_byte

  csr_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .start_o(start_evt),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte),
    .tx_req_o(tx_req),
    .tx_byte_i(tx_byte)
  );

  // Open drain: the line is only ever pulled low.
  assign sda_o = 1'b0;
  assign tx_byte = read_byte(ptr_ff, cur_ff, volt_ff);

  // Status pins come from the analog side and pass two flip-flops each.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      good_sync_ff <= 2'h0;
      ovp_sync_ff <= 2'h0;
      pres_sync_ff <= 2'h0;
      cell_sync0_ff <= 2'h0;
      cell_sync1_ff <= 2'h0;
      lin_sync_ff <= 2'h0;
      pre_sync_ff <= 2'h0;
      minsys_sync_ff <= 2'h0;
      good_prev_ff <= 1'b0;
      pres_prev_ff <= 1'b0;
    end else begin
      good_sync_ff <= {good_sync_ff[0], input_source_good_i};
      ovp_sync_ff <= {ovp_sync_ff[0], input_overvoltage_i};
      pres_sync_ff <= {pres_sync_ff[0], cell_count_battery_presence_i};
      cell_sync0_ff <= cell_count_sel_i;
      cell_sync1_ff <= cell_sync0_ff;
      lin_sync_ff <= {lin_sync_ff[0], linear_regulation_mode_i};
      pre_sync_ff <= {pre_sync_ff[0], battery_below_precharge_i};
      minsys_sync_ff <= {minsys_sync_ff[0], battery_below_min_system_i};
      good_prev_ff <= good_sync_ff[1];
      pres_prev_ff <= pres_sync_ff[1];
    end
  end

  // The cell count strap is taken once, after the synchroniser has filled past release.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      cells_ff <= 2'h0;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == csr_pkg::CSR_STRAP_WAIT) begin
        strap_done_ff <= 1'b1;
        cells_ff <= cell_sync1_ff;
      end
    end
  end

  // Byte sequencing: first byte is the register pointer, then lower byte, then upper byte.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ptr_ff <= csr_pkg::CSR_PTR_RESET;
      first_ff <= 1'b0;
      have_lsb_ff <= 1'b0;
      lsb_hold_ff <= 8'h00;
    end else if (start_evt) begin
      first_ff <= 1'b1;
      have_lsb_ff <= 1'b0;
    end else if (rx_valid && first_ff) begin
      ptr_ff <= rx_byte;
      first_ff <= 1'b0;
    end else if (rx_valid) begin
      // The lower byte is only held and the pointer steps; no setpoint changes until its partner arrives.
      have_lsb_ff <= ~ptr_ff[0];
      lsb_hold_ff <= rx_byte;
      ptr_ff <= ptr_ff + 8'h01;
    end else if (tx_req) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // Whole-word commit strobes; an upper byte without a lower byte before it is dropped.
  assign data_wr = rx_valid & ~first_ff & have_lsb_ff;
  assign wr_word = {rx_byte, lsb_hold_ff};
  assign cur_wr = data_wr & (ptr_ff == csr_pkg::CSR_CUR_MSB_ADDR);
  assign volt_wr = data_wr & (ptr_ff == csr_pkg::CSR_VOLT_MSB_ADDR);
  assign volt_field = wr_word[csr_pkg::CSR_VOLT_MSB_POS:csr_pkg::CSR_VOLT_LSB_POS];
  assign volt_zero_wr = volt_wr & ~wr_word[csr_pkg::CSR_VOLT_BAD_POS] &
                        (volt_field == 12'h000);

  // Falling source good clears unless overvoltage is the cause; falling presence always clears.
  // Input overcurrent, thermal shutdown, system overvoltage and latch-off have no path here.
  assign fault_clear = (good_prev_ff & ~good_sync_ff[1] & ~ovp_sync_ff[1]) |
                       (pres_prev_ff & ~pres_sync_ff[1]);

  // Current setpoint; clears win over a write in the same cycle for safety.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_ff <= csr_pkg::CSR_CUR_RESET;
    end else if (fault_clear || volt_zero_wr) begin
      cur_ff <= csr_pkg::CSR_CUR_RESET;
    end else if (cur_wr && wr_word[15:csr_pkg::CSR_CUR_BAD_LSB] == 3'h0) begin
      // Lower byte bits 5..0 are simply not stored.
      cur_ff <= wr_word[csr_pkg::CSR_CUR_HI_MSB:csr_pkg::CSR_CUR_HI_LSB];
    end
  end

  // Voltage setpoint; it holds the one-cell code until the strap has been read.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      volt_ff <= csr_pkg::CSR_VOLT_DEF_1S;
    end else if (!strap_done_ff) begin
      if (strap_cnt_ff == csr_pkg::CSR_STRAP_WAIT) begin
        volt_ff <= volt_default(cell_sync1_ff);
      end
    end else if (volt_zero_wr) begin
      volt_ff <= volt_default(cells_ff);
    end else if (volt_wr && !wr_word[csr_pkg::CSR_VOLT_BAD_POS] &&
                 volt_field >= csr_pkg::CSR_VOLT_MIN &&
                 volt_field <= csr_pkg::CSR_VOLT_MAX) begin
      volt_ff <= volt_field;
    end
  end

  // Current clamp and path switch mode from cell count and battery comparators.
  always_comb begin
    nxt_limit = cur_ff;
    nxt_linear = 1'b0;
    if (cells_ff == 2'h0) begin
      if (pre_sync_ff[1]) begin
        nxt_linear = lin_sync_ff[1];
        if (cur_ff > csr_pkg::CSR_PRECHG_CLAMP) nxt_limit = csr_pkg::CSR_PRECHG_CLAMP;
      end else if (minsys_sync_ff[1]) begin
        nxt_linear = 1'b1;
        if (cur_ff > csr_pkg::CSR_LINEAR_CLAMP) nxt_limit = csr_pkg::CSR_LINEAR_CLAMP;
      end
    end else if (minsys_sync_ff[1]) begin
      nxt_linear = lin_sync_ff[1];
      if (cur_ff > csr_pkg::CSR_PRECHG_CLAMP) nxt_limit = csr_pkg::CSR_PRECHG_CLAMP;
    end
  end

  // Registered outputs; the voltage in force is the default until the host writes one.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      charge_enable_o <= 1'b0;
      charge_current_code_o <= csr_pkg::CSR_CUR_RESET;
      charge_voltage_code_o <= csr_pkg::CSR_VOLT_DEF_1S;
      battery_path_switch_linear_o <= 1'b0;
    end else begin
      charge_enable_o <= good_sync_ff[1] & (cur_ff != 7'h00);
      charge_current_code_o <= good_sync_ff[1] ? nxt_limit : 7'h00;
      charge_voltage_code_o <= volt_ff;
      battery_path_switch_linear_o <= nxt_linear;
    end
  end
endmodule : csr_top
`default_nettype wire

/* File: core/csr_pkg.sv */
// Constants shared by the charge setpoint register bank and its serial port.
`default_nettype none
package csr_pkg;
  // Register byte addresses of the two setpoint words.
  localparam logic [7:0] CSR_CUR_LSB_ADDR = 8'h02;
  localparam logic [7:0] CSR_CUR_MSB_ADDR = 8'h03;
  localparam logic [7:0] CSR_VOLT_LSB_ADDR = 8'h04;
  localparam logic [7:0] CSR_VOLT_MSB_ADDR = 8'h05;
  // Field widths.
  localparam int CSR_CUR_W = 7;
  localparam int CSR_VOLT_W = 12;
  // Field positions inside the 16-bit words.
  localparam int CSR_CUR_HI_LSB = 6;
  localparam int CSR_CUR_HI_MSB = 12;
  localparam int CSR_CUR_BAD_LSB = 13;
  localparam int CSR_VOLT_LSB_POS = 3;
  localparam int CSR_VOLT_MSB_POS = 14;
  localparam int CSR_VOLT_BAD_POS = 15;
  // Reset values.
  localparam logic [6:0] CSR_CUR_RESET = 7'h00;
  localparam logic [7:0] CSR_PTR_RESET = 8'h00;
  // Voltage codes in 8 mV steps: 4200, 8400, 12600, 16800 mV and the legal range.
  localparam logic [11:0] CSR_VOLT_DEF_1S = 12'h20D;
  localparam logic [11:0] CSR_VOLT_DEF_2S = 12'h41A;
  localparam logic [11:0] CSR_VOLT_DEF_3S = 12'h627;
  localparam logic [11:0] CSR_VOLT_DEF_4S = 12'h834;
  localparam logic [11:0] CSR_VOLT_MIN = 12'h080;
  localparam logic [11:0] CSR_VOLT_MAX = 12'h960;
  // Current clamps in 64 mA steps: 384 mA precharge, 1984 mA (largest code under 2 A).
  localparam logic [6:0] CSR_PRECHG_CLAMP = 7'h06;
  localparam logic [6:0] CSR_LINEAR_CLAMP = 7'h1F;
  // Cycles after reset release before the cell count strap is taken.
  localparam logic [1:0] CSR_STRAP_WAIT = 2'h3;
  // Serial port bit counter values.
  localparam logic [3:0] CSR_BIT_LAST = 4'h7;
  localparam logic [3:0] CSR_BIT_FULL = 4'h8;
endpackage : csr_pkg
`default_nettype wire

/* File: core/csr_i2c_slave.sv */
// Byte level serial management port slave with address match and open-drain data.
`timescale 1ns/1ps
`default_nettype none
module csr_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary value.
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  output logic start_o,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_req_o,
  input wire logic [7:0] tx_byte_i
);
  typedef enum logic [2:0] {
    CSR_IDLE, CSR_ADDR, CSR_ADDR_ACK, CSR_WR, CSR_WR_ACK, CSR_RD, CSR_RD_ACK
  } csr_i2c_state_t;

  csr_i2c_state_t state_ff;
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shreg_ff;
  logic rw_ff;
  logic acked_ff;
  logic drive_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Pins pass two flip-flops; edges are taken only from the second stage onward.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_i};
      sda_sync_ff <= {sda_sync_ff[0], sda_i};
      scl_prev_ff <= scl_sync_ff[1];
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  assign scl_rise = scl_sync_ff[1] & ~scl_prev_ff;
  assign scl_fall = ~scl_sync_ff[1] & scl_prev_ff;
  assign start_det = scl_sync_ff[1] & scl_prev_ff & sda_prev_ff & ~sda_sync_ff[1];
  assign stop_det = scl_sync_ff[1] & scl_prev_ff & ~sda_prev_ff & sda_sync_ff[1];

  // Bit engine: sample on the clock rise, change the data line on the clock fall.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= CSR_IDLE;
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      rw_ff <= 1'b0;
      acked_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= CSR_ADDR;
      bit_cnt_ff <= 4'h0;
      drive_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= CSR_IDLE;
      drive_ff <= 1'b0;
    end else if (scl_rise) begin
      case (state_ff)
        CSR_ADDR, CSR_WR: begin
          shreg_ff <= {shreg_ff[6:0], sda_sync_ff[1]};
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
        CSR_RD: bit_cnt_ff <= bit_cnt_ff + 4'h1;
        CSR_RD_ACK: acked_ff <= ~sda_sync_ff[1];
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_ff)
        CSR_ADDR: begin
          if (bit_cnt_ff == csr_pkg::CSR_BIT_FULL) begin
            if (shreg_ff[7:1] == DEV_ADDR) begin
              state_ff <= CSR_ADDR_ACK;
              rw_ff <= shreg_ff[0];
              drive_ff <= 1'b1;
            end else begin
              state_ff <= CSR_IDLE;
            end
          end
        end
        CSR_ADDR_ACK, CSR_WR_ACK: begin
          bit_cnt_ff <= 4'h0;
          if (rw_ff) begin
            state_ff <= CSR_RD;
            shreg_ff <= tx_byte_i;
            drive_ff <= ~tx_byte_i[7];
          end else begin
            state_ff <= CSR_WR;
            drive_ff <= 1'b0;
          end
        end
        CSR_WR: begin
          if (bit_cnt_ff == csr_pkg::CSR_BIT_FULL) begin
            state_ff <= CSR_WR_ACK;
            drive_ff <= 1'b1;
          end
        end
        CSR_RD: begin
          if (bit_cnt_ff == csr_pkg::CSR_BIT_FULL) begin
            state_ff <= CSR_RD_ACK;
            drive_ff <= 1'b0;
          end else begin
            shreg_ff <= {shreg_ff[6:0], 1'b0};
            drive_ff <= ~shreg_ff[6];
          end
        end
        CSR_RD_ACK: begin
          bit_cnt_ff <= 4'h0;
          if (acked_ff) begin
            state_ff <= CSR_RD;
            shreg_ff <= tx_byte_i;
            drive_ff <= ~tx_byte_i[7];
          end else begin
            state_ff <= CSR_IDLE;
          end
        end
        default: state_ff <= CSR_IDLE;
      endcase
    end
  end

  // Strobes to the register bank; a read byte is requested on the fall that loads it.
  assign sda_oe_o = drive_ff;
  assign start_o = start_det;
  assign rx_byte_o = shreg_ff;
  assign rx_valid_o = scl_fall & (state_ff == CSR_WR) & (bit_cnt_ff == csr_pkg::CSR_BIT_FULL);
  assign tx_req_o = scl_fall & ((state_ff == CSR_ADDR_ACK & rw_ff) | (state_ff == CSR_RD_ACK & acked_ff));
endmodule : csr_i2c_slave
`default_nettype wire

/* File: test/csr_top_properties.sv */
// Concurrent checks on the charge setpoint register bank ports.
`timescale 1ns/1ps
`default_nettype none
module csr_top_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic input_source_good_i,
  input wire logic input_overvoltage_i,
  input wire logic cell_count_battery_presence_i,
  input wire logic [1:0] cell_count_sel_i,
  input wire logic linear_regulation_mode_i,
  input wire logic battery_below_precharge_i,
  input wire logic battery_below_min_system_i,
  input wire logic charge_enable_o,
  input wire logic [6:0] charge_current_code_o,
  input wire logic [11:0] charge_voltage_code_o,
  input wire logic battery_path_switch_linear_o
);
  // Six steady cycles cover the two sync flops plus the output register.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  chk_reset_cur_zero: assert property ($past(reset_i) |-> charge_current_code_o == 7'h00
    && !charge_enable_o) else $error("current not zero after reset");
  chk_enable_needs_code: assert property (charge_enable_o |-> charge_current_code_o != 7'h00)
    else $error("enable without current");
  chk_source_drop_clear: assert property ($fell(input_source_good_i) && !input_overvoltage_i
    |-> ##[1:6] charge_current_code_o == 7'h00) else $error("source drop kept current");
  chk_presence_drop_clear: assert property ($fell(cell_count_battery_presence_i)
    |-> ##[1:6] (charge_current_code_o == 7'h00 && !charge_enable_o))
    else $error("removal kept current");
  chk_multi_precharge_clamp: assert property ((cell_count_sel_i != 2'h0
    && battery_below_min_system_i)[*6] |-> charge_current_code_o <= 7'h06)
    else $error("multi cell precharge not clamped");
  chk_multi_linear_mode: assert property ((cell_count_sel_i != 2'h0 && linear_regulation_mode_i
    && battery_below_min_system_i)[*6] |-> battery_path_switch_linear_o)
    else $error("multi cell precharge not linear");
  chk_single_precharge_clamp: assert property ((cell_count_sel_i == 2'h0
    && battery_below_precharge_i)[*6] |-> charge_current_code_o <= 7'h06)
    else $error("single cell precharge not clamped");
  chk_single_band_clamp: assert property ((cell_count_sel_i == 2'h0 && !battery_below_precharge_i
    && battery_below_min_system_i)[*6] |-> charge_current_code_o <= 7'h1F
    && battery_path_switch_linear_o) else $error("single cell band not clamped");
  chk_volt_in_range: assert property (charge_voltage_code_o >= 12'h080
    && charge_voltage_code_o <= 12'h960) else $error("voltage code out of range");
endmodule : csr_top_checker
`default_nettype wire

/* File: test/csr_host.sv */
// Host model that writes setpoint words over the serial management bus.
`timescale 1ns/1ps
`default_nettype none
module csr_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Clock and data idle released; the clock stands still between frames.
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_clk
  logic ack_dummy;
  // Data moves only two cycles after the clock fall so no false start is seen.
  task automatic send_bit(input logic b);
    wait_clk(2);
    sda_oe_o = ~b;
    wait_clk(8);
    scl_o = 1'b1;
    wait_clk(10);
    ack_dummy = sda_i;
    scl_o = 1'b0;
  endtask : send_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i]);
    end
    send_bit(1'b1);
    ack = ~ack_dummy;
  endtask : send_byte
  // Start or repeated start: release data, raise the clock, then pull data low.
  task automatic start_cond();
    wait_clk(2);
    sda_oe_o = 1'b0;
    wait_clk(8);
    scl_o = 1'b1;
    wait_clk(10);
    sda_oe_o = 1'b1;
    wait_clk(10);
    scl_o = 1'b0;
  endtask : start_cond
  // Stop: data low under a low clock, raise the clock, then release data.
  task automatic stop_cond();
    wait_clk(2);
    sda_oe_o = 1'b1;
    wait_clk(8);
    scl_o = 1'b1;
    wait_clk(10);
    sda_oe_o = 1'b0;
    wait_clk(10);
  endtask : stop_cond
  // Bits are taken at the end of the clock high; a low ack asks the slave for more.
  task automatic recv_byte(input logic more, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1);
      b[i] = ack_dummy;
    end
    send_bit(~more);
  endtask : recv_byte
  // Whole word, lower byte first, inside one transaction.
  task automatic write_word(input logic [6:0] addr, input logic [7:0] ptr,
                            input logic [15:0] word, output logic [3:0] acks);
    start_cond();
    send_byte({addr, 1'b0}, acks[3]);
    send_byte(ptr, acks[2]);
    send_byte(word[7:0], acks[1]);
    send_byte(word[15:8], acks[0]);
    stop_cond();
  endtask : write_word
  // Pointer write, repeated start, then both bytes back with the lower byte first.
  task automatic read_word(input logic [6:0] addr, input logic [7:0] ptr,
                           output logic [15:0] word, output logic [2:0] acks);
    start_cond();
    send_byte({addr, 1'b0}, acks[2]);
    send_byte(ptr, acks[1]);
    start_cond();
    send_byte({addr, 1'b1}, acks[0]);
    recv_byte(1'b1, word[7:0]);
    recv_byte(1'b0, word[15:8]);
    stop_cond();
  endtask : read_word
endmodule : csr_host
`default_nettype wire

/* File: test/testbench.sv */
// Self-checking bench for the charge setpoint register bank.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, reset, scl, sda, host_oe, dut_sda, dut_oe, src_good, ovp, pres, lin;
  logic below_pre, below_min, enable, sw_lin;
  logic [1:0] cells;
  logic [6:0] cur;
  logic [11:0] volt;
  logic [11:0] cur_w;
  logic [11:0] en_w;
  logic [11:0] lin_w;
  int bad_count = 0;
  // Zero-extended views so that one compare task serves every result.
  assign cur_w = {5'h00, cur};
  assign en_w = {11'h000, enable};
  assign lin_w = {11'h000, sw_lin};
  int tests_run = 0;
  // Open-drain data line with pull-up: low while any party pulls.
  assign sda = ~(host_oe | (dut_oe & ~dut_sda));
  csr_top i_csr_top (.clk_i(clk), .reset_i(reset), .scl_i(scl), .sda_i(sda), .sda_o(dut_sda),
    .sda_oe_o(dut_oe), .input_source_good_i(src_good), .input_overvoltage_i(ovp),
    .cell_count_battery_presence_i(pres), .cell_count_sel_i(cells),
    .linear_regulation_mode_i(lin), .battery_below_precharge_i(below_pre),
    .battery_below_min_system_i(below_min), .charge_enable_o(enable),
    .charge_current_code_o(cur), .charge_voltage_code_o(volt),
    .battery_path_switch_linear_o(sw_lin));
  csr_host i_csr_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask : settle
  task automatic do_reset(input logic [1:0] n);
    cells = n;
    reset = 1'b1;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    settle();
  endtask : do_reset
  task automatic wr(input logic [7:0] ptr, input logic [15:0] w, input logic [6:0] a,
                    input logic [3:0] exp_ack);
    logic [3:0] acks;
    i_csr_host.write_word(a, ptr, w, acks);
    settle();
    chk({8'h00, acks}, {8'h00, exp_ack});
  endtask : wr
  task automatic rd(input logic [7:0] ptr, input logic [15:0] exp);
    logic [15:0] w;
    logic [2:0] acks;
    i_csr_host.read_word(7'h2A, ptr, w, acks);
    settle();
    chk({9'h000, acks}, 12'h007);
    chk({4'h0, w[15:8]}, {4'h0, exp[15:8]});
    chk({4'h0, w[7:0]}, {4'h0, exp[7:0]});
  endtask : rd
  task automatic t_current();
    wr(8'h02, 16'h1FFF, 7'h2A, 4'hF);
    chk(cur_w, 12'h07F);
    chk(en_w, 12'h001);
    wr(8'h02, 16'h0040, 7'h2A, 4'hF);
    chk(cur_w, 12'h001);
    wr(8'h02, 16'h20C0, 7'h2A, 4'hF);
    chk(cur_w, 12'h001);
    wr(8'h03, 16'h1F1F, 7'h2A, 4'hF);
    chk(cur_w, 12'h001);
    wr(8'h06, 16'h1FFF, 7'h2A, 4'hF);
    wr(8'h02, 16'h1FFF, 7'h2B, 4'h0);
    chk(cur_w, 12'h001);
    rd(8'h02, 16'h0040);
    $display("test current done");
  endtask : t_current
  task automatic t_voltage();
    logic [11:0] code [5] = '{12'h07F, 12'h961, 12'h080, 12'h960, 12'h100};
    logic [11:0] exp [5] = '{12'h41A, 12'h41A, 12'h080, 12'h960, 12'h960};
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, {(i == 4), code[i], 3'h7}, 7'h2A, 4'hF);
      chk(volt, exp[i]);
    end
    wr(8'h04, 16'h2000, 7'h2A, 4'hF);
    wr(8'h02, 16'h0400, 7'h2A, 4'hF);
    chk(volt, 12'h400);
    chk(cur_w, 12'h010);
    rd(8'h04, 16'h2000);
    wr(8'h04, 16'h0007, 7'h2A, 4'hF);
    chk(volt, 12'h41A);
    chk(cur_w, 12'h000);
    $display("test voltage done");
  endtask : t_voltage
  task automatic t_faults();
    wr(8'h02, 16'h0400, 7'h2A, 4'hF);
    ovp = 1'b1;
    settle();
    src_good = 1'b0;
    settle();
    src_good = 1'b1;
    settle();
    ovp = 1'b0;
    settle();
    chk(cur_w, 12'h010);
    src_good = 1'b0;
    settle();
    src_good = 1'b1;
    settle();
    chk(cur_w, 12'h000);
    wr(8'h02, 16'h0400, 7'h2A, 4'hF);
    pres = 1'b0;
    settle();
    pres = 1'b1;
    settle();
    chk(cur_w, 12'h000);
    $display("test faults done");
  endtask : t_faults
  task automatic t_clamps();
    wr(8'h02, 16'h1FC0, 7'h2A, 4'hF);
    below_min = 1'b1;
    settle();
    chk(cur_w, 12'h006);
    chk(lin_w, 12'h001);
    lin = 1'b0;
    settle();
    chk(lin_w, 12'h000);
    lin = 1'b1;
    below_min = 1'b0;
    settle();
    chk(cur_w, 12'h07F);
    do_reset(2'h0);
    chk(volt, 12'h20D);
    chk(cur_w, 12'h000);
    wr(8'h02, 16'h1FC0, 7'h2A, 4'hF);
    below_pre = 1'b1;
    below_min = 1'b1;
    settle();
    chk(cur_w, 12'h006);
    below_pre = 1'b0;
    settle();
    chk(cur_w, 12'h01F);
    chk(lin_w, 12'h001);
    below_min = 1'b0;
    settle();
    chk(cur_w, 12'h07F);
    do_reset(2'h2);
    chk(volt, 12'h627);
    do_reset(2'h3);
    chk(volt, 12'h834);
    $display("test clamps done");
  endtask : t_clamps
  // Main sequence; inputs change on the falling edge.
  initial begin
    {reset, src_good, ovp, pres, lin, below_pre, below_min} = 7'h6C;
    cells = 2'h1;
    do_reset(2'h1);
    chk(cur_w, 12'h000);
    chk(volt, 12'h41A);
    $display("test defaults done");
    t_current();
    t_voltage();
    t_faults();
    t_clamps();
    close_out();
  end
  // Hang guard well above the expected run length.
  initial begin
    #1250000;
    bad_count++;
    close_out();
  end
endmodule : testbench
bind csr_top csr_top_checker i_chk (.clk_i(clk_i), .reset_i(reset_i),
  .input_source_good_i(input_source_good_i), .input_overvoltage_i(input_overvoltage_i),
  .cell_count_battery_presence_i(cell_count_battery_presence_i),
  .cell_count_sel_i(cell_count_sel_i), .linear_regulation_mode_i(linear_regulation_mode_i),
  .battery_below_precharge_i(battery_below_precharge_i),
  .battery_below_min_system_i(battery_below_min_system_i), .charge_enable_o(charge_enable_o),
  .charge_current_code_o(charge_current_code_o), .charge_voltage_code_o(charge_voltage_code_o),
  .battery_path_switch_linear_o(battery_path_switch_linear_o));
`default_nettype wire
